// [shared/sdrcal_pkg.sv]
// Shared constants and types for the calibration and bank access link
package sdrcal_pkg;
	localparam int          NUM_BANKS    = 8;
	localparam int          BANK_W       = 3;
	localparam int          ROW_W        = 14;
	localparam int          COL_W        = 10;
	localparam int          MA_W         = 8;
	localparam int          DQ_W         = 16;

	// Mode register addresses
	localparam logic [7:0]  MA_CAL       = 8'h0a;
	localparam logic [7:0]  MA_BANK_MASK = 8'h10;
	localparam logic [7:0]  MA_SEG_MASK  = 8'h11;
	localparam logic [7:0]  MA_PAT_A     = 8'h20;
	localparam logic [7:0]  MA_PAT_B     = 8'h28;
	localparam logic [7:0]  MA_RESET     = 8'h3f;
	localparam logic [7:0]  MA_INFO      = 8'h00;

	// Calibration codes
	localparam logic [7:0]  CAL_INIT     = 8'hff;
	localparam logic [7:0]  CAL_LONG     = 8'hab;
	localparam logic [7:0]  CAL_SHORT    = 8'h56;
	localparam logic [7:0]  CAL_RESET    = 8'hc3;

	// Reset values, fixed read patterns and info bit index
	localparam logic [7:0]  MASK_RST     = 8'h00;
	localparam logic [7:0]  PAT_A_VAL    = 8'h00;
	localparam logic [7:0]  PAT_B_VAL    = 8'h3c;
	localparam logic [7:0]  INFO_RST     = 8'h00;
	localparam int          INFO_REF_BIT = 0;

	// Command encodings on cmd bits 3:0
	localparam logic [3:0]  CMD_ACT      = 4'h2;
	localparam logic [3:0]  CMD_RD       = 4'h5;
	localparam logic [3:0]  CMD_WR       = 4'h1;
	localparam logic [3:0]  CMD_PRE      = 4'hb;
	localparam logic [3:0]  CMD_MRW      = 4'h0;
	localparam logic [3:0]  CMD_MRR      = 4'h8;

	// Timing, ns and cycles at 25 MHz
	localparam int          TCK_NS       = 40;
	localparam int          TRCD_NS      = 18;
	localparam int          TRC_NS       = 60;
	localparam int          TRRD_NS      = 10;
	localparam int          TFAW_NS      = 50;
	localparam int          TRPPB_NS     = 18;
	localparam int          TRPAB_NS     = 21;
	localparam int          TRCD_CYC     = (TRCD_NS + TCK_NS - 1) / TCK_NS;
	localparam int          TRC_CYC      = (TRC_NS + TCK_NS - 1) / TCK_NS;
	localparam int          TRRD_CYC     = (TRRD_NS + TCK_NS - 1) / TCK_NS;
	localparam int          TFAW_CYC     = (TFAW_NS + TCK_NS - 1) / TCK_NS;
	localparam int          TRPPB_CYC    = (TRPPB_NS + TCK_NS - 1) / TCK_NS;
	localparam int          TRPAB_CYC    = (TRPAB_NS + TCK_NS - 1) / TCK_NS + 1;
	localparam int          FAW_MAX      = 4;
	localparam int          RL_CYC       = 3;
	localparam int          TCCD_CYC     = 2;

	// Host register map over Wishbone
	localparam logic [3:0]  HR_CMD       = 4'h0;
	localparam logic [3:0]  HR_ADDR      = 4'h4;
	localparam logic [3:0]  HR_STAT      = 4'h8;
	localparam logic [3:0]  HR_RDATA     = 4'hc;
	localparam int          HC_OP_LSB    = 0;
	localparam int          HC_BL_LSB    = 4;
	localparam int          HC_DATA_LSB  = 8;
	localparam int          HA_COL_LSB   = 0;
	localparam int          HA_ROW_LSB   = 10;
	localparam int          HA_BANK_LSB  = 24;
	localparam int          HA_ALL_BIT   = 27;

	typedef enum logic [2:0] {
		SDRCAL_OP_NONE, SDRCAL_OP_ACT, SDRCAL_OP_RD, SDRCAL_OP_WR,
		SDRCAL_OP_PRE, SDRCAL_OP_MRW, SDRCAL_OP_MRR
	} sdrcal_op_t;
endpackage : sdrcal_pkg

// [shared/sdrcal_if.sv]
// Command, address and read data link between controller and device
`timescale 1ns/100ps
interface sdrcal_if;
	logic        cs_n;
	logic [3:0]  cmd;
	logic [19:0] ca;
	logic [7:0]  dq_o;
	logic        dq_oe;
	logic        dqs_o;
	logic        dqs_oe;
	logic        ref_pin_vdd;

	modport ctrl (output cs_n, output cmd, output ca, input dq_o, input dq_oe,
		input dqs_o, input dqs_oe);
	modport dev  (input cs_n, input cmd, input ca, output dq_o, output dq_oe,
		output dqs_o, output dqs_oe, input ref_pin_vdd);
endinterface : sdrcal_if

// [rtl/sdrcal_bank_tmr.sv]
// One down counter used for bank timing windows
`timescale 1ns/100ps
module sdrcal_bank_tmr #(
	parameter int W = 4
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] val_i,
	output logic              busy_o
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (load_i) begin
			cnt_q <= val_i;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign busy_o = (cnt_q != '0);
endmodule : sdrcal_bank_tmr

// [rtl/sdrcal_ctrl.sv]
// Controller end: Wishbone slave that issues timed commands to the device
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
module sdrcal_ctrl (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	sdrcal_if.ctrl           link
);
	localparam int TW = 4;
	localparam int NB = sdrcal_pkg::NUM_BANKS;

	logic [31:0]  cmd_q;
	logic [31:0]  adr_q;
	logic         pend_q;
	logic         err_q;
	logic [7:0]   rdata_q;
	logic [3:0]   cmd_o_q;
	logic         cs_n_q;
	logic [19:0]  ca_q;
	logic [2:0]   faw_cnt;
	logic         refused;
	logic [NB-1:0] rcd_busy, rc_busy, rp_busy, open_q;
	logic         rrd_busy, ccd_busy, load_rrd, load_ccd;
	logic [NB-1:0] load_act, load_pre;
	logic [TW-1:0] pre_val;
	logic         fire;
	logic         ok;
	logic [2:0]   op;
	logic [2:0]   bank;

	assign op   = cmd_q[sdrcal_pkg::HC_OP_LSB +: 3];
	assign bank = adr_q[sdrcal_pkg::HA_BANK_LSB +: 3];
	// Reserved calibration codes in SDRCAL_OP_MRW orders never reach the link
	assign refused = (op == 3'(sdrcal_pkg::SDRCAL_OP_MRW)) &
		(adr_q[7:0] == sdrcal_pkg::MA_CAL) &
		!(cmd_q[15:8] inside {sdrcal_pkg::CAL_INIT, sdrcal_pkg::CAL_LONG,
		sdrcal_pkg::CAL_SHORT, sdrcal_pkg::CAL_RESET});

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave, answers one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_adr_i == sdrcal_pkg::HR_STAT) begin
				wb_dat_o <= {24'h00_0000, open_q[5:0], err_q, pend_q};
			end else if (wb_adr_i == sdrcal_pkg::HR_RDATA) begin
				wb_dat_o <= {24'h00_0000, rdata_q};
			end else if (wb_adr_i == sdrcal_pkg::HR_CMD) begin
				wb_dat_o <= cmd_q;
			end else if (wb_adr_i == sdrcal_pkg::HR_ADDR) begin
				wb_dat_o <= adr_q;
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Order registers; a command write arms one issue
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_q  <= 32'h0000_0000;
			adr_q  <= 32'h0000_0000;
			pend_q <= 1'b0;
			err_q  <= 1'b0;
		end else begin
			if (wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o) begin
				if (wb_adr_i == sdrcal_pkg::HR_ADDR) begin
					adr_q <= wb_dat_i;
				end else if (wb_adr_i == sdrcal_pkg::HR_CMD) begin
					cmd_q  <= wb_dat_i;
					pend_q <= 1'b1;
					err_q  <= 1'b0;
				end
			end else if (fire) begin
				pend_q <= 1'b0;
			end
			// Refused order is dropped and flagged; the set comes last and wins
			if (pend_q & refused) begin
				pend_q <= 1'b0;
				err_q  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-bank timers and the four-activate window
	genvar g;
	generate
		for (g = 0; g < NB; g++) begin : g_bank
			sdrcal_bank_tmr #(.W(TW)) u_rcd (.clk_i(clk_i), .rst_i(rst_i),
				.load_i(load_act[g]), .val_i(TW'(sdrcal_pkg::TRCD_CYC)),
				.busy_o(rcd_busy[g]));
			sdrcal_bank_tmr #(.W(TW)) u_rc (.clk_i(clk_i), .rst_i(rst_i),
				.load_i(load_act[g]), .val_i(TW'(sdrcal_pkg::TRC_CYC)),
				.busy_o(rc_busy[g]));
			sdrcal_bank_tmr #(.W(TW)) u_rp (.clk_i(clk_i), .rst_i(rst_i),
				.load_i(load_pre[g]), .val_i(pre_val),
				.busy_o(rp_busy[g]));
			assign load_act[g] = fire & (op == 3'(sdrcal_pkg::SDRCAL_OP_ACT)) &
				(bank == 3'(g));
			assign load_pre[g] = fire & (op == 3'(sdrcal_pkg::SDRCAL_OP_PRE)) &
				(adr_q[sdrcal_pkg::HA_ALL_BIT] | (bank == 3'(g)));
		end
	endgenerate

	assign pre_val = adr_q[sdrcal_pkg::HA_ALL_BIT] ? TW'(sdrcal_pkg::TRPAB_CYC) :
		TW'(sdrcal_pkg::TRPPB_CYC);
	assign load_rrd = |load_act;
	assign load_ccd = fire & (op inside {3'(sdrcal_pkg::SDRCAL_OP_RD),
		3'(sdrcal_pkg::SDRCAL_OP_WR)});

	sdrcal_bank_tmr #(.W(TW)) u_rrd (.clk_i(clk_i), .rst_i(rst_i), .load_i(load_rrd),
		.val_i(TW'(sdrcal_pkg::TRRD_CYC)), .busy_o(rrd_busy));
	// Every read and write loads TCCD_CYC; the burst length field is not used
	sdrcal_bank_tmr #(.W(TW)) u_ccd (.clk_i(clk_i), .rst_i(rst_i), .load_i(load_ccd),
		.val_i(TW'(sdrcal_pkg::TCCD_CYC)), .busy_o(ccd_busy));

	// Window of TFAW_CYC - 1 cycles counted; TFAW_CYC rounded up from ns
	logic [sdrcal_pkg::TFAW_CYC-1:0] faw_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			faw_q <= '0;
		end else begin
			faw_q <= {faw_q[sdrcal_pkg::TFAW_CYC-2:0], load_rrd};
		end
	end
	always_comb begin
		faw_cnt = 3'h0;
		for (int i = 0; i < sdrcal_pkg::TFAW_CYC - 1; i++) begin
			faw_cnt = faw_cnt + 3'(faw_q[i]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Issue check
	always_comb begin
		ok = 1'b1;
		case (op)
			3'(sdrcal_pkg::SDRCAL_OP_ACT): begin
				ok = !open_q[bank] && !rc_busy[bank] && !rp_busy[bank] && !rrd_busy &&
					(faw_cnt < 3'(sdrcal_pkg::FAW_MAX));
			end
			3'(sdrcal_pkg::SDRCAL_OP_RD), 3'(sdrcal_pkg::SDRCAL_OP_WR): begin
				ok = open_q[bank] && !rcd_busy[bank] && !ccd_busy;
			end
			3'(sdrcal_pkg::SDRCAL_OP_MRW): begin
				ok = !refused;
			end
			default: ok = 1'b1;
		endcase
	end
	assign fire = pend_q & ok & !err_q & (op != 3'(sdrcal_pkg::SDRCAL_OP_NONE));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			open_q <= '0;
		end else begin
			open_q <= (open_q | load_act) & ~load_pre;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link drive; one cycle per command
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs_n_q  <= 1'b1;
			cmd_o_q <= 4'hf;
			ca_q    <= 20'h0_0000;
		end else if (fire) begin
			cs_n_q <= 1'b0;
			case (op)
				3'(sdrcal_pkg::SDRCAL_OP_ACT): cmd_o_q <= sdrcal_pkg::CMD_ACT;
				3'(sdrcal_pkg::SDRCAL_OP_RD):  cmd_o_q <= sdrcal_pkg::CMD_RD;
				3'(sdrcal_pkg::SDRCAL_OP_WR):  cmd_o_q <= sdrcal_pkg::CMD_WR;
				3'(sdrcal_pkg::SDRCAL_OP_PRE): cmd_o_q <= sdrcal_pkg::CMD_PRE;
				3'(sdrcal_pkg::SDRCAL_OP_MRR): cmd_o_q <= sdrcal_pkg::CMD_MRR;
				default:                       cmd_o_q <= sdrcal_pkg::CMD_MRW;
			endcase
			if (op == 3'(sdrcal_pkg::SDRCAL_OP_ACT)) begin
				ca_q <= {3'h0, bank, adr_q[sdrcal_pkg::HA_ROW_LSB +: 14]};
			end else if (op inside {3'(sdrcal_pkg::SDRCAL_OP_RD),
				3'(sdrcal_pkg::SDRCAL_OP_WR)}) begin
				ca_q <= {7'h00, bank, adr_q[9:0]};
			end else if (op == 3'(sdrcal_pkg::SDRCAL_OP_PRE)) begin
				ca_q <= {adr_q[sdrcal_pkg::HA_ALL_BIT], 16'h0000, bank};
			end else begin
				ca_q <= {4'h0, cmd_q[15:8], adr_q[7:0]};
			end
		end else begin
			cs_n_q  <= 1'b1;
			cmd_o_q <= 4'hf;
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.cmd  = cmd_o_q;
	assign link.ca   = ca_q;

	// First strobe rise captures the read byte
	logic dqs_d1_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dqs_d1_q <= 1'b0;
			rdata_q  <= 8'h00;
		end else begin
			dqs_d1_q <= link.dqs_o & link.dqs_oe;
			if (link.dqs_oe & link.dqs_o & !dqs_d1_q) begin
				rdata_q <= link.dq_o;
			end
		end
	end
endmodule : sdrcal_ctrl

// [rtl/sdrcal_dev.sv]
// Device end: command decode, bank state, mode registers and read strobe
`timescale 1ns/100ps
module sdrcal_dev #(
	parameter int RL = sdrcal_pkg::RL_CYC
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	sdrcal_if.dev                     link,
	output logic [7:0]                bank_mask_o,
	output logic [7:0]                seg_mask_o,
	output logic [2:0]                cal_kind_o,
	output logic                      cal_pulse_o,
	output logic                      dev_reset_o,
	output logic [7:0]                open_banks_o,
	output logic [13:0]               last_row_o,
	output logic [9:0]                last_col_o,
	output logic                      last_wr_o
);
	logic        act, col, mode_register_write_cmd, mrr, pre, is_cal_ok;
	logic [7:0]  info_q;
	logic [13:0] rows_q [0:7];
	logic [RL:0] rd_pipe_q;
	logic [7:0]  rd_val_q;
	logic [7:0]  mrr_data;
	logic [7:0]  dq_q;
	logic        dq_oe_q, dqs_q, dqs_oe_q;

	assign act = !link.cs_n && (link.cmd[1:0] == 2'b10);
	assign col = !link.cs_n && (link.cmd[1:0] == 2'b01);
	assign pre = !link.cs_n && (link.cmd == sdrcal_pkg::CMD_PRE);
	assign mode_register_write_cmd = !link.cs_n && (link.cmd == sdrcal_pkg::CMD_MRW);
	assign mrr = !link.cs_n && (link.cmd == sdrcal_pkg::CMD_MRR);
	assign is_cal_ok = link.ca[15:8] inside {sdrcal_pkg::CAL_INIT, sdrcal_pkg::CAL_LONG,
		sdrcal_pkg::CAL_SHORT, sdrcal_pkg::CAL_RESET};

	////////////////////////////////////////////////////////////////////////
	// Mode registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bank_mask_o <= sdrcal_pkg::MASK_RST;
			seg_mask_o  <= sdrcal_pkg::MASK_RST;
			cal_kind_o  <= 3'h0;
			cal_pulse_o <= 1'b0;
			dev_reset_o <= 1'b0;
			info_q      <= sdrcal_pkg::INFO_RST;
		end else begin
			cal_pulse_o <= 1'b0;
			dev_reset_o <= 1'b0;
			if (mode_register_write_cmd && link.ca[7:0] == sdrcal_pkg::MA_BANK_MASK) begin
				bank_mask_o <= link.ca[15:8];
			end else if (mode_register_write_cmd && link.ca[7:0] == sdrcal_pkg::MA_SEG_MASK) begin
				seg_mask_o <= link.ca[15:8];
			end else if (mode_register_write_cmd && link.ca[7:0] == sdrcal_pkg::MA_RESET) begin
				dev_reset_o <= 1'b1;
				bank_mask_o <= sdrcal_pkg::MASK_RST;
				seg_mask_o  <= sdrcal_pkg::MASK_RST;
			end else if (mode_register_write_cmd && link.ca[7:0] == sdrcal_pkg::MA_CAL && is_cal_ok &&
				!link.ref_pin_vdd) begin
				cal_pulse_o <= 1'b1;
				if (link.ca[15:8] == sdrcal_pkg::CAL_INIT) begin
					cal_kind_o <= 3'h1;
					info_q[sdrcal_pkg::INFO_REF_BIT] <= 1'b1;
				end else if (link.ca[15:8] == sdrcal_pkg::CAL_LONG) begin
					cal_kind_o <= 3'h2;
				end else if (link.ca[15:8] == sdrcal_pkg::CAL_SHORT) begin
					cal_kind_o <= 3'h3;
				end else begin
					cal_kind_o <= 3'h4;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bank state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			open_banks_o <= 8'h00;
			last_row_o   <= 14'h0000;
			last_col_o   <= 10'h000;
			last_wr_o    <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				rows_q[i] <= 14'h0000;
			end
		end else begin
			if (act) begin
				open_banks_o[link.ca[16:14]] <= 1'b1;
				rows_q[link.ca[16:14]]       <= link.ca[13:0];
			end else if (pre && link.ca[19]) begin
				open_banks_o <= 8'h00;
			end else if (pre) begin
				open_banks_o[link.ca[2:0]] <= 1'b0;
			end
			if (col && open_banks_o[link.ca[12:10]]) begin
				last_row_o <= rows_q[link.ca[12:10]];
				last_col_o <= link.ca[9:0];
				last_wr_o  <= !link.cmd[2];
			end
		end
	end

	assign mrr_data = (link.ca[7:0] == sdrcal_pkg::MA_PAT_A) ? sdrcal_pkg::PAT_A_VAL :
		(link.ca[7:0] == sdrcal_pkg::MA_PAT_B) ? sdrcal_pkg::PAT_B_VAL :
		(link.ca[7:0] == sdrcal_pkg::MA_INFO) ? info_q : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Read latency pipe and strobe; a later read overwrites the byte still in the pipe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_pipe_q <= '0;
			rd_val_q  <= 8'h00;
		end else begin
			rd_pipe_q <= {rd_pipe_q[RL-1:0], (col && link.cmd[2]) || mrr};
			if (mrr) begin
				rd_val_q <= mrr_data;
			end else if (col && link.cmd[2]) begin
				rd_val_q <= link.ca[7:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dq_q     <= 8'h00;
			dq_oe_q  <= 1'b0;
			dqs_q    <= 1'b0;
			dqs_oe_q <= 1'b0;
		end else begin
			dqs_oe_q <= rd_pipe_q[RL-2] | rd_pipe_q[RL-1];
			dqs_q    <= rd_pipe_q[RL-1];
			dq_oe_q  <= rd_pipe_q[RL-1];
			dq_q     <= rd_pipe_q[RL-1] ? rd_val_q : 8'h00;
		end
	end

	assign link.dq_o   = dq_q;
	assign link.dq_oe  = dq_oe_q;
	assign link.dqs_o  = dqs_q;
	assign link.dqs_oe = dqs_oe_q;
endmodule : sdrcal_dev

// [testbench/sdrcal_monitor.sv]
// Link checker for command order and read strobe timing
`timescale 1ns/100ps
module sdrcal_monitor (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cs_n,
	input  wire logic [3:0]  cmd,
	input  wire logic [19:0] ca,
	input  wire logic [7:0]  dq_o,
	input  wire logic        dq_oe,
	input  wire logic        dqs_o,
	input  wire logic        dqs_oe
);
	logic [7:0] open_q;
	logic       act;
	logic       rd;
	logic       col;
	logic       pre;
	logic       mode_register_write_cmd;
	logic       mrr;
	assign act = !cs_n && cmd == sdrcal_pkg::CMD_ACT;
	assign rd  = !cs_n && cmd == sdrcal_pkg::CMD_RD;
	assign col = rd || (!cs_n && cmd == sdrcal_pkg::CMD_WR);
	assign pre = !cs_n && cmd == sdrcal_pkg::CMD_PRE;
	assign mode_register_write_cmd = !cs_n && cmd == sdrcal_pkg::CMD_MRW;
	assign mrr = !cs_n && cmd == sdrcal_pkg::CMD_MRR;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	// Open bank shadow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			open_q <= 8'h00;
		end else if (act) begin
			open_q[ca[16:14]] <= 1'b1;
		end else if (pre) begin
			open_q <= ca[19] ? 8'h00 : open_q & ~(8'h01 << ca[2:0]);
		end
	end
	////////////////////////////////////////
	cs_pulse_a: assert property (!cs_n |=> cs_n)
		else $error("chip select low too long");
	col_open_a: assert property (col |-> open_q[ca[12:10]])
		else $error("column command to closed bank");
	act_closed_a: assert property (act |-> !open_q[ca[16:14]])
		else $error("activate to open bank");
	pre_all_a: assert property ((pre && ca[19]) |=> !act)
		else $error("activate too soon after precharge all");
	cal_code_a: assert property ((mode_register_write_cmd && ca[7:0] == sdrcal_pkg::MA_CAL) |->
		ca[15:8] inside {8'hff, 8'hab, 8'h56, 8'hc3}) else $error("reserved calibration code");
	rd_strobe_a: assert property ((rd || mrr) |-> ##3 (dqs_oe && !dqs_o)
		##1 (dqs_o && dq_oe) ##1 !dqs_o) else $error("read strobe timing wrong");
	rd_data_a: assert property (rd |-> ##4 dq_o == $past(ca[7:0], 4))
		else $error("read byte wrong");
	preamble_a: assert property ($rose(dqs_oe) |-> !dqs_o)
		else $error("strobe preamble missing");
	strobe_en_a: assert property (dqs_o |-> dqs_oe && dq_oe)
		else $error("strobe without enable");
	act_c: cover property (act);
	rd_c: cover property (rd);
	mrw_c: cover property (mode_register_write_cmd);
	pre_all_c: cover property (pre && ca[19]);
endmodule : sdrcal_monitor

// [testbench/testbench.sv]
// Testbench joining controller and device over the link
`timescale 1ns/100ps
module testbench;
	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [3:0]  wb_adr;
	logic [31:0] wb_dat;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [7:0]  bank_mask;
	logic [7:0]  seg_mask;
	logic [2:0]  cal_kind;
	logic        cal_pulse;
	logic        dev_reset;
	logic [7:0]  open_banks;
	logic [13:0] last_row;
	logic [9:0]  last_col;
	logic        last_wr;
	logic        cal_seen;
	logic [2:0]  kind_seen;
	logic        rst_seen;
	logic [31:0] rd;
	int          error_cnt;
	int          checks_done;
	sdrcal_if u_sdrcal_if ();
	sdrcal_ctrl u_sdrcal_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(u_sdrcal_if));
	sdrcal_dev u_sdrcal_dev (.clk_i(clk_i), .rst_i(rst_i), .link(u_sdrcal_if),
		.bank_mask_o(bank_mask), .seg_mask_o(seg_mask), .cal_kind_o(cal_kind),
		.cal_pulse_o(cal_pulse), .dev_reset_o(dev_reset), .open_banks_o(open_banks),
		.last_row_o(last_row), .last_col_o(last_col), .last_wr_o(last_wr));
	sdrcal_monitor u_sdrcal_monitor (.clk_i(clk_i), .rst_i(rst_i),
		.cs_n(u_sdrcal_if.cs_n), .cmd(u_sdrcal_if.cmd), .ca(u_sdrcal_if.ca),
		.dq_o(u_sdrcal_if.dq_o), .dq_oe(u_sdrcal_if.dq_oe), .dqs_o(u_sdrcal_if.dqs_o),
		.dqs_oe(u_sdrcal_if.dqs_oe));
	////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (cal_pulse === 1'b1) begin
			cal_seen = 1'b1;
			kind_seen = cal_kind;
		end
		if (dev_reset === 1'b1) begin
			rst_seen = 1'b1;
		end
	end
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= dat;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
		end
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb
	function automatic logic [31:0] ad(input logic a, input logic [2:0] b,
		input logic [13:0] r, input logic [9:0] c);
		return {4'h0, a, b, r, c};
	endfunction : ad
	task automatic op(input logic [2:0] code, input logic [31:0] adr, input logic [7:0] dat);
		int n;
		cal_seen = 1'b0;
		rst_seen = 1'b0;
		n = 0;
		wb(1'b1, sdrcal_pkg::HR_ADDR, adr);
		wb(1'b1, sdrcal_pkg::HR_CMD, {16'h0000, dat, 5'h00, code});
		do begin
			wb(1'b0, sdrcal_pkg::HR_STAT, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 8);
		if (rd[0] !== 1'b0) begin
			error_cnt++;
		end
		repeat (8) @(posedge clk_i);
	endtask : op
	////////////////////////////////////////
	task automatic t_reset();
		check(u_sdrcal_if.cs_n, 32'h1);
		check(u_sdrcal_if.cmd, 32'hf);
		check(bank_mask, sdrcal_pkg::MASK_RST);
		check(seg_mask, sdrcal_pkg::MASK_RST);
		check(open_banks, 32'h0);
		wb(1'b0, 4'h2, 32'h0);
		check(rd, 32'h0);
	endtask : t_reset
	task automatic t_cal();
		logic [7:0] codes [4] = '{sdrcal_pkg::CAL_INIT, sdrcal_pkg::CAL_LONG,
			sdrcal_pkg::CAL_SHORT, sdrcal_pkg::CAL_RESET};
		for (int i = 0; i < 4; i++) begin
			op(3'h5, ad(1'b0, 3'h0, 14'h0, {2'h0, sdrcal_pkg::MA_CAL}), codes[i]);
			check(cal_seen, 32'h1);
			check(kind_seen, 32'(i + 1));
		end
		op(3'h5, ad(1'b0, 3'h0, 14'h0, {2'h0, sdrcal_pkg::MA_CAL}), 8'h12);
		check(cal_seen, 32'h0);
		wb(1'b0, sdrcal_pkg::HR_STAT, 32'h0);
		check(rd[1], 32'h1);
		@(posedge clk_i);
		u_sdrcal_if.ref_pin_vdd <= 1'b1;
		op(3'h5, ad(1'b0, 3'h0, 14'h0, {2'h0, sdrcal_pkg::MA_CAL}), sdrcal_pkg::CAL_LONG);
		check(cal_seen, 32'h0);
		u_sdrcal_if.ref_pin_vdd <= 1'b0;
		op(3'h5, ad(1'b0, 3'h0, 14'h0, {2'h0, sdrcal_pkg::MA_CAL}), sdrcal_pkg::CAL_SHORT);
		check(cal_seen, 32'h1);
	endtask : t_cal
	task automatic t_regs();
		op(3'h5, ad(1'b0, 3'h0, 14'h0, {2'h0, sdrcal_pkg::MA_BANK_MASK}), 8'ha5);
		check(bank_mask, 32'ha5);
		op(3'h5, ad(1'b0, 3'h0, 14'h0, {2'h0, sdrcal_pkg::MA_SEG_MASK}), 8'h5a);
		check(seg_mask, 32'h5a);
		op(3'h6, ad(1'b0, 3'h0, 14'h0, {2'h0, sdrcal_pkg::MA_PAT_B}), 8'h00);
		wb(1'b0, sdrcal_pkg::HR_RDATA, 32'h0);
		check(rd[7:0], sdrcal_pkg::PAT_B_VAL);
		op(3'h6, ad(1'b0, 3'h0, 14'h0, {2'h0, sdrcal_pkg::MA_PAT_A}), 8'h00);
		wb(1'b0, sdrcal_pkg::HR_RDATA, 32'h0);
		check(rd[7:0], sdrcal_pkg::PAT_A_VAL);
		op(3'h6, ad(1'b0, 3'h0, 14'h0, {2'h0, sdrcal_pkg::MA_INFO}), 8'h00);
		wb(1'b0, sdrcal_pkg::HR_RDATA, 32'h0);
		check(rd[7:0], 32'h01 << sdrcal_pkg::INFO_REF_BIT);
		op(3'h5, ad(1'b0, 3'h0, 14'h0, {2'h0, sdrcal_pkg::MA_RESET}), 8'h96);
		check(rst_seen, 32'h1);
		check(bank_mask, 32'h0);
		check(seg_mask, 32'h0);
	endtask : t_regs
	task automatic t_access();
		op(3'h1, ad(1'b0, 3'h3, 14'h2abc, 10'h0), 8'h00);
		check(open_banks, 32'h08);
		wb(1'b0, sdrcal_pkg::HR_STAT, 32'h0);
		check(rd[7:2], 32'h08);
		op(3'h2, ad(1'b0, 3'h3, 14'h0, 10'h1a5), 8'h00);
		check(last_row, 32'h2abc);
		check(last_col, 32'h1a5);
		check(last_wr, 32'h0);
		wb(1'b0, sdrcal_pkg::HR_RDATA, 32'h0);
		check(rd[7:0], 32'ha5);
		op(3'h3, ad(1'b0, 3'h3, 14'h0, 10'h0f0), 8'h00);
		check(last_col, 32'h0f0);
		check(last_wr, 32'h1);
	endtask : t_access
	task automatic t_banks();
		logic [2:0] b [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
		for (int i = 0; i < 5; i++) begin
			op(3'h1, ad(1'b0, b[i], 14'(i), 10'h0), 8'h00);
		end
		check(open_banks, 32'h3f);
		op(3'h4, ad(1'b0, 3'h3, 14'h0, 10'h0), 8'h00);
		check(open_banks, 32'h37);
		op(3'h4, ad(1'b1, 3'h0, 14'h0, 10'h0), 8'h00);
		check(open_banks, 32'h00);
		op(3'h1, ad(1'b0, 3'h7, 14'h1, 10'h0), 8'h00);
		check(open_banks, 32'h80);
	endtask : t_banks
	task automatic finish_test();
		$display("checks=%0d errors=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////
	initial begin
		#(40 * 10000);
		error_cnt++;
		finish_test();
	end
	initial begin
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 4'h0;
		wb_dat = 32'h0;
		cal_seen = 1'b0;
		kind_seen = 3'h0;
		rst_seen = 1'b0;
		error_cnt = 0;
		checks_done = 0;
		u_sdrcal_if.ref_pin_vdd = 1'b0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_cal();
		t_regs();
		t_access();
		t_banks();
		finish_test();
	end
endmodule : testbench
